// [rtl/fdc_consts.vh]
// Constants for the frequency deviation configuration block.
// Assumes inclusion by bare name from every design file of the block.
//
// Summary of operation
// - In 2-FSK/GFSK transmit the deviation is fref/2^17 times (8 + mantissa) times 2^exponent.
// - In 2-FSK/GFSK transmit a zero shifts below the carrier and a one above it by the deviation.
// - In MSK transmit the mantissa picks a phase turn lasting (mantissa+1)/8 symbol, +90 for zero, -90 for one.
// - ASK transmit and MSK or ASK receive ignore the exponent and mantissa entirely.
// - In 2-FSK/GFSK receive the configured deviation is the deviation the demodulator expects.
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define FDC_ADDR_W 16
`define FDC_DEV_OFFSET 16'hDF11
`define FDC_STAT_OFFSET 16'hDF40
`define FDC_EXP_MSB 6
`define FDC_EXP_LSB 4
`define FDC_MANT_MSB 2
`define FDC_MANT_LSB 0
`define FDC_EXP_RESET 3'h4
`define FDC_MANT_RESET 3'h7
`define FDC_WRITE_MASK 8'h77

// ****************************************************************
// Modulation formats and scaling
// ****************************************************************
`define FDC_MOD_2FSK 3'h0
`define FDC_MOD_GFSK 3'h1
`define FDC_MOD_ASK 3'h3
`define FDC_MOD_MSK 3'h7
`define FDC_MANT_BIAS 4'h8
`define FDC_DEV_SHIFT 17
`define FDC_STEP_W 18
`define FDC_SYM_EIGHTHS 4'h8

`endif

// [rtl/fdc_dev_calc.v]
// Deviation word calculator for 2-FSK and GFSK.
// Assumes the reference frequency is given as a step in units of fref/2^17 per symbol tick.
`include "fdc_consts.vh"

module fdc_dev_calc
#(
  parameter STEP_W = `FDC_STEP_W
)
(
  input wire [2:0] exponent,
  input wire [2:0] mantissa,
  output wire [STEP_W-1:0] dev_word
);

  wire [3:0] scaled_mant;

  // Deviation word in units of fref/2^17.
  assign scaled_mant = `FDC_MANT_BIAS + {1'b0, mantissa};
  assign dev_word = {{(STEP_W-4){1'b0}}, scaled_mant} << exponent;

endmodule // fdc_dev_calc

// [rtl/fdc_msk_phase.v]
// MSK phase turn timer.
// Assumes sym_start pulses once per symbol and eighth_tick pulses eight times per symbol.
`include "fdc_consts.vh"

module fdc_msk_phase
(
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire sym_start,
  input wire eighth_tick,
  input wire sym_bit,
  input wire [2:0] mantissa,
  output reg turning_reg,
  output reg turn_dir_reg
);

  reg [3:0] count_reg;
  reg [3:0] count_next;
  wire [3:0] length;

  // Turn lasts (mantissa + 1) eighths of a symbol.
  assign length = {1'b0, mantissa} + 4'h1;

  always @*
  begin
    count_next = count_reg;
    if (sym_start)
      count_next = 4'h0;
    else if (eighth_tick && count_reg < `FDC_SYM_EIGHTHS)
      count_next = count_reg + 4'h1;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= 4'h0;
      turning_reg <= 1'b0;
      turn_dir_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      turning_reg <= enable && (count_next < length);
      if (sym_start)
        turn_dir_reg <= sym_bit;
    end
  end

endmodule // fdc_msk_phase

// [rtl/fdc_top.v]
// Frequency deviation setting register with its modulator and demodulator outputs.
// Assumes an Avalon-MM master with waitrequest and a datapath in the same clock domain.
//
// Local design decision: register access over Avalon-MM.
`include "fdc_consts.vh"

module fdc_top
#(
  parameter STEP_W = `FDC_STEP_W
)
(
  input wire clk,
  input wire resetn,
  input wire [`FDC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire tx_active,
  input wire rx_active,
  input wire [2:0] mod_format,
  input wire sym_bit,
  input wire sym_start,
  input wire eighth_tick,
  output reg [STEP_W-1:0] tx_freq_offset,
  output reg tx_freq_negative,
  output reg tx_freq_valid,
  output reg msk_turning,
  output reg msk_turn_negative,
  output reg [STEP_W-1:0] rx_expected_dev,
  output reg rx_dev_valid
);

  // ****************************************************************
  // Register storage and bus access
  // ****************************************************************
  reg [2:0] exp_reg;
  reg [2:0] mant_reg;
  reg ack_reg;
  wire [7:0] dev_value;
  wire hit_dev;
  wire hit_stat;
  wire req;
  wire [STEP_W-1:0] dev_word;
  wire fsk_fmt;
  wire msk_fmt;
  wire msk_turning_w;
  wire msk_dir_w;
  wire [7:0] status_value;

  function is_fsk;
    input [2:0] fmt;
    begin
      is_fsk = (fmt == `FDC_MOD_2FSK) || (fmt == `FDC_MOD_GFSK);
    end
  endfunction

  assign dev_value = {1'b0, exp_reg, 1'b0, mant_reg};
  assign hit_dev = (avs_address == `FDC_DEV_OFFSET);
  assign hit_stat = (avs_address == `FDC_STAT_OFFSET);
  assign req = (avs_read || avs_write) && !ack_reg;
  assign fsk_fmt = is_fsk(mod_format);
  assign msk_fmt = (mod_format == `FDC_MOD_MSK);
  assign status_value = {3'h0, msk_turning, tx_freq_negative, rx_dev_valid, tx_freq_valid, msk_fmt};

  // Every access is answered one cycle after it is presented.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      exp_reg <= `FDC_EXP_RESET;
      mant_reg <= `FDC_MANT_RESET;
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end
    else
    begin
      ack_reg <= req;
      avs_waitrequest <= !req;
      if (req)
      begin
        avs_response <= (hit_dev || hit_stat) ? 2'h0 : 2'h2;
        if (avs_read)
        begin
          if (hit_dev)
            avs_readdata <= {24'h000000, dev_value};
          else if (hit_stat)
            avs_readdata <= {24'h000000, status_value};
          else
            avs_readdata <= 32'h00000000;
        end
        if (avs_write && hit_dev && avs_byteenable[0])
        begin
          exp_reg <= avs_writedata[`FDC_EXP_MSB:`FDC_EXP_LSB];
          mant_reg <= avs_writedata[`FDC_MANT_MSB:`FDC_MANT_LSB];
        end
      end
    end
  end

  // ****************************************************************
  // Datapath outputs
  // ****************************************************************
  fdc_dev_calc #(
    .STEP_W(STEP_W)
  ) u_calc (
    .exponent(exp_reg),
    .mantissa(mant_reg),
    .dev_word(dev_word)
  );

  fdc_msk_phase u_msk (
    .clk(clk),
    .resetn(resetn),
    .enable(tx_active && msk_fmt),
    .sym_start(sym_start),
    .eighth_tick(eighth_tick),
    .sym_bit(sym_bit),
    .mantissa(mant_reg),
    .turning_reg(msk_turning_w),
    .turn_dir_reg(msk_dir_w)
  );

  // Fields reach the datapath only in the formats that use them; elsewhere outputs rest at zero.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_freq_offset <= {STEP_W{1'b0}};
      tx_freq_negative <= 1'b0;
      tx_freq_valid <= 1'b0;
      msk_turning <= 1'b0;
      msk_turn_negative <= 1'b0;
      rx_expected_dev <= {STEP_W{1'b0}};
      rx_dev_valid <= 1'b0;
    end
    else
    begin
      tx_freq_valid <= tx_active && fsk_fmt;
      tx_freq_offset <= (tx_active && fsk_fmt) ? dev_word : {STEP_W{1'b0}};
      tx_freq_negative <= tx_active && fsk_fmt && !sym_bit;
      msk_turning <= msk_turning_w && tx_active && msk_fmt;
      msk_turn_negative <= msk_turning_w && msk_dir_w && tx_active && msk_fmt;
      rx_dev_valid <= rx_active && fsk_fmt;
      rx_expected_dev <= (rx_active && fsk_fmt) ? dev_word : {STEP_W{1'b0}};
    end
  end

endmodule // fdc_top

// [verification/fdc_datapath_model.sv]
// Symbol timing source standing in for the modem datapath.
// Assumes one symbol lasts 16 clocks with an eighth tick on the first clock of every eighth.
module fdc_datapath_model
(
  input wire logic clk,
  input wire logic resetn,
  output logic sym_start,
  output logic eighth_tick,
  output logic sym_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_reg;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= 5'h00;
    else
      cnt_reg <= cnt_reg + 5'h01;
  end
  assign sym_start = (cnt_reg[3:0] == 4'h0);
  assign eighth_tick = !cnt_reg[0];
  assign sym_bit = cnt_reg[4];
endmodule // fdc_datapath_model

// [verification/fdc_monitor.sv]
// Port checker for the deviation register block.
// Assumes it is bound to fdc_top and shares its clock and reset.
module fdc_monitor
#(
  parameter STEP_W = 18
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic [2:0] mod_format,
  input wire logic sym_bit,
  input wire logic sym_start,
  input wire logic [STEP_W-1:0] tx_freq_offset,
  input wire logic tx_freq_negative,
  input wire logic tx_freq_valid,
  input wire logic msk_turning,
  input wire logic msk_turn_negative,
  input wire logic rx_dev_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_TX_VALID: assert property (tx_active && mod_format < 3'h2 |=> tx_freq_valid) else $error("no tx");
  AST_TX_SIDE: assert property (
    tx_active && mod_format < 3'h2 |=> tx_freq_negative == !$past(sym_bit)) else $error("bad side");
  AST_MSK_DIR: assert property (msk_turn_negative |-> msk_turning) else $error("bad turn");
  AST_MSK_SIDE: assert property (
    sym_start && tx_active && mod_format == 3'h7 ##1 tx_active && mod_format == 3'h7
    |=> msk_turning && msk_turn_negative == $past(sym_bit, 2)) else $error("bad msk turn");
  AST_ASK_IDLE: assert property (
    mod_format == 3'h3 |=> !tx_freq_valid && tx_freq_offset == '0 && !msk_turning) else $error("ask used");
  AST_MSK_RX: assert property (
    !tx_active && mod_format == 3'h7 |=> !rx_dev_valid && !msk_turning) else $error("msk rx used");
  AST_RX_VALID: assert property (rx_active && mod_format < 3'h2 |=> rx_dev_valid) else $error("no rx");
  AST_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
endmodule // fdc_monitor

bind fdc_top fdc_monitor #(.STEP_W(STEP_W)) u_mon (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tx_active(tx_active), .rx_active(rx_active),
  .mod_format(mod_format), .sym_bit(sym_bit), .sym_start(sym_start), .tx_freq_offset(tx_freq_offset),
  .tx_freq_negative(tx_freq_negative),
  .tx_freq_valid(tx_freq_valid), .msk_turning(msk_turning), .msk_turn_negative(msk_turn_negative),
  .rx_dev_valid(rx_dev_valid));

// [verification/tb.sv]
// Self-checking bench for the deviation register block.
// Assumes the design, the datapath model and the checker are compiled first.
`include "fdc_consts.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: %h %h", \
  $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, rd = 0, wr = 0, txa = 0, rxa = 0, sst, etk, sbit, wreq, tneg, tval, mt, mtn, rval;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [2:0] fmt = 0;
  logic [1:0] resp;
  logic [17:0] off, rxd, e;
  logic [7:0] cnt, cntn;
  logic [7:0] dv [2] = '{8'h00, 8'h77};
  int fails = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  fdc_datapath_model MDL (.clk(clk), .resetn(resetn), .sym_start(sst), .eighth_tick(etk), .sym_bit(sbit));
  fdc_top DUT (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .avs_response(resp), .tx_active(txa),
    .rx_active(rxa), .mod_format(fmt), .sym_bit(sbit), .sym_start(sst), .eighth_tick(etk), .tx_freq_offset(off),
    .tx_freq_negative(tneg), .tx_freq_valid(tval), .msk_turning(mt), .msk_turn_negative(mtn),
    .rx_expected_dev(rxd), .rx_dev_valid(rval));
  task conclude;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    n = 0;
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0)
    begin
      n++;
      if (n > 40)
      begin
        fails++;
        conclude;
      end
      @(posedge clk);
    end
    q = rdat;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task automatic mode(input logic t, input logic r, input logic [2:0] f);
    txa <= t;
    rxa <= r;
    fmt <= f;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    acc(0, `FDC_DEV_OFFSET, 0);
    `CHK(q, 32'h47)
    acc(1, `FDC_DEV_OFFSET, 8'hFF);
    acc(0, `FDC_DEV_OFFSET, 0);
    `CHK(q, 32'h77)
    for (int i = 0; i < 2; i++)
    begin
      acc(1, `FDC_DEV_OFFSET, dv[i]);
      e = (18'h8 + dv[i][2:0]) << dv[i][6:4];
      mode(1, 0, i);
      `CHK(off, e)
      mode(0, 1, i);
      `CHK(rxd, e)
      acc(0, `FDC_STAT_OFFSET, 0);
      `CHK({resp, q}, {2'h0, 32'h4})
    end
    mode(1, 0, 3'h3);
    `CHK({off, tval}, 19'h0)
    mode(0, 1, 3'h7);
    `CHK(rval, 1'b0)
    acc(1, `FDC_DEV_OFFSET, 8'h25);
    mode(1, 0, 3'h7);
    cnt = 0;
    cntn = 0;
    repeat (32)
    begin
      @(posedge clk);
      cnt = cnt + mt;
      cntn = cntn + mtn;
    end
    `CHK(cnt, 8'h4 * (8'h5 + 8'h1))
    `CHK(cntn, 8'h2 * (8'h5 + 8'h1))
    acc(0, 16'h0000, 0);
    `CHK({resp, q}, {2'h2, 32'h0})
    conclude;
  end
endmodule // tb
